// ---- rtl/pmsc_top.sv ----
// State control of a four-channel power monitor: sampling sequencer, sleep,
// power-down, slow-rate pin and snapshots of the readable results.
// Assumes a converter that answers each start with one done pulse, and a
// classic Wishbone host on the core clock.
//
// Summary of operation
// - Auto sleep between cycles when rate below 1024 SPS or channels fewer than four.
// - Sleep keeps all digital state and stored data.
// - Sleep entered or left by writing sampling mode then a snapshot command.
// - No other cause puts the device to sleep.
// - SMBus timeout enable applies in both sleep and active states.
// - Power-down only by pin low; everything including bus inactive.
// - Power-down loses all state; resumes with defaults when pin returns high.
// - Power-on flag set on every reset; readable and clearable by host.
// - Slow pin high forces 8 SPS from the next round-robin cycle.
// - With pin as alert output it no longer controls rate.
// - Single-shot with slow pin asserted starts sampling about 1 ms later.
// - Slow pin does not start sampling while in sleep.
// - Each slow pin change may run a limited clearing or non-clearing snapshot.
// - Limited snapshot applies no pending control changes.
// - Results stable within 1 ms of a triggering pin edge.
// - Slow config selects snapshot kind, per-edge disables, reports level and edges.
// - Bus voltage per channel stored 16-bit; 14 MSBs times sense accumulated.
// - Bus voltage unipolar by default, two's complement in bipolar mode.
// - Sense voltage 16-bit, unsigned by default, two's complement if bidirectional.
// - Clearing snapshot latches results and resets accumulators; non-clearing keeps them.
`timescale 1ns/1ns
`default_nettype none
module pmsc_top #(
  parameter int unsigned CYC_1024 = pmsc_pkg::T_RATE_1024_NS / pmsc_pkg::CLK_PERIOD_NS,
  parameter int unsigned CYC_256 = pmsc_pkg::T_RATE_256_NS / pmsc_pkg::CLK_PERIOD_NS,
  parameter int unsigned CYC_64 = pmsc_pkg::T_RATE_64_NS / pmsc_pkg::CLK_PERIOD_NS,
  parameter int unsigned CYC_8 = pmsc_pkg::T_RATE_8_NS / pmsc_pkg::CLK_PERIOD_NS,
  parameter int unsigned CYC_WARMUP = pmsc_pkg::T_WARMUP_NS / pmsc_pkg::CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone slave
  input wire pmsc_pkg::pmsc_wb_req_t wb_req,
  output logic wb_ack,
  output logic [31:0] wb_dat_o,
  // Pins
  input wire logic power_down_pin,
  input wire logic slow_pin_in,
  output logic first_alert_output,
  output logic first_alert_oe,
  // Converter
  output logic adc_start,
  output logic [1:0] adc_chan,
  input wire pmsc_pkg::pmsc_adc_res_t adc_res,
  // State
  output logic analog_sleep,
  output logic smbus_timeout_en,
  output logic powered_down
);
  import pmsc_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_WARMUP, ST_START, ST_CONVERT} pmsc_state_t;

  // ==========================================================
  // Pins and core reset
  logic pd_level, slow_level, slow_prev, core_rst;

  pmsc_sync #(.RESET_VAL(1'b0)) u_pd_sync (.clk(clk), .rst(rst), .pin(power_down_pin), .level(pd_level));
  pmsc_sync #(.RESET_VAL(1'b0)) u_slow_sync (.clk(clk), .rst(rst), .pin(slow_pin_in), .level(slow_level));

  // Power-down wipes the whole core, bus slave included
  assign core_rst = rst | ~pd_level;

  // ==========================================================
  // State
  pmsc_ctrl_t ctrl_pend, ctrl_act;
  pmsc_slow_t slow_cfg;
  logic apply_pending, por_flag;
  pmsc_state_t state;
  logic [1:0] ch, rate_cur;
  logic [PERIOD_W-1:0] period_cnt, warm_cnt;
  logic [RES_W-1:0] live_bus [NUM_CH], live_sense [NUM_CH], rd_bus [NUM_CH], rd_sense [NUM_CH];
  logic [PROD_W-1:0] live_power [NUM_CH], rd_power [NUM_CH];
  logic [ACC_W-1:0] acc [NUM_CH], rd_acc [NUM_CH];
  logic [CNT_W-1:0] acc_count, rd_count;

  // ==========================================================
  // Bus decode
  logic req, wr_en, wr_ctrl, wr_cmd, wr_status, wr_slow;
  logic [7:0] res_off;
  logic [31:0] read_word;

  assign req = wb_req.cyc & wb_req.stb;
  // A write lands on the edge where the master sees ack
  assign wr_en = req & wb_req.we & wb_ack;
  assign res_off = wb_req.adr - ADDR_RES_BASE;
  assign wr_ctrl = wr_en && wb_req.adr == ADDR_CTRL;
  assign wr_cmd = wr_en && wb_req.adr == ADDR_CMD && wb_req.sel[0];
  assign wr_status = wr_en && wb_req.adr == ADDR_STATUS && wb_req.sel[0];
  assign wr_slow = wr_en && wb_req.adr == ADDR_SLOW && wb_req.sel[0];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    read_word = 32'h0;
    if (wb_req.adr == ADDR_CTRL) begin
      read_word = ctrl_pend;
    end else if (wb_req.adr == ADDR_STATUS) begin
      read_word[STAT_POR_BIT] = por_flag;
      read_word[STAT_SLEEP_BIT] = analog_sleep;
      read_word[STAT_SLOW_BIT] = slow_level;
      read_word[STAT_BUSY_BIT] = state != ST_IDLE;
    end else if (wb_req.adr == ADDR_SLOW) begin
      read_word = slow_cfg;
    end else if (wb_req.adr == ADDR_COUNT) begin
      read_word = rd_count;
    end else if (wb_req.adr >= ADDR_RES_BASE && wb_req.adr <= ADDR_RES_END) begin
      case (res_off[4:2])
        RES_BUS: read_word = {16'h0, rd_bus[res_off[6:5]]};
        RES_SENSE: read_word = {16'h0, rd_sense[res_off[6:5]]};
        RES_POWER: read_word = {2'h0, rd_power[res_off[6:5]]};
        RES_ACC_LO: read_word = rd_acc[res_off[6:5]][31:0];
        RES_ACC_HI: read_word = {8'h0, rd_acc[res_off[6:5]][ACC_W-1:32]};
        default: read_word = 32'h0;
      endcase
    end
  end

  // Answers one cycle after the request; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (core_rst) begin
      wb_ack <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack <= req & ~wb_ack;
      if (req & ~wb_ack & ~wb_req.we) begin
        wb_dat_o <= read_word;
      end
    end
  end

  // ==========================================================
  // Control registers and snapshot requests
  logic slow_rise, slow_fall, pin_snap, cmd_snap, snap_go, snap_clear, idle_apply;

  assign slow_rise = slow_level & ~slow_prev & ~ctrl_act.alert_sel;
  assign slow_fall = ~slow_level & slow_prev & ~ctrl_act.alert_sel;
  assign pin_snap = (slow_rise & ~slow_cfg.rise_dis) | (slow_fall & ~slow_cfg.fall_dis);
  assign cmd_snap = wr_cmd & (wb_req.dat[CMD_SNAP_CLR_BIT] | wb_req.dat[CMD_SNAP_KEEP_BIT]);
  assign snap_go = pin_snap | cmd_snap;
  // A command and a pin edge in one cycle make one snapshot; the command picks its kind
  assign snap_clear = cmd_snap ? wb_req.dat[CMD_SNAP_CLR_BIT] : ~slow_cfg.keep_acc;
  // Pending control moves in only between round-robin cycles
  assign idle_apply = apply_pending && state == ST_IDLE;

  always_ff @(posedge clk) begin
    if (core_rst) begin
      ctrl_pend <= CTRL_RESET;
      ctrl_act <= CTRL_RESET;
      apply_pending <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_pend <= merge(ctrl_pend, wb_req.dat, wb_req.sel);
      end
      // Only a commanded snapshot arms the apply; pin snapshots never do
      if (cmd_snap) begin
        apply_pending <= 1'b1;
      end else if (idle_apply) begin
        apply_pending <= 1'b0;
      end
      if (idle_apply) begin
        ctrl_act <= ctrl_pend;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      por_flag <= 1'b1;
    end else if (wr_status & wb_req.dat[STAT_POR_BIT]) begin
      por_flag <= 1'b0;
    end
  end

  // Edge flags: a new edge beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (core_rst) begin
      slow_cfg <= SLOW_RESET;
      // Follow the pin through power-down so a high pin makes no false edge on its release; after rst the synchroniser restarts from 0
      slow_prev <= slow_level;
    end else begin
      slow_prev <= slow_level;
      slow_cfg.level <= slow_level;
      if (wr_slow) begin
        slow_cfg.keep_acc <= wb_req.dat[0];
        slow_cfg.rise_dis <= wb_req.dat[1];
        slow_cfg.fall_dis <= wb_req.dat[2];
      end
      slow_cfg.rise_seen <= slow_rise | (slow_cfg.rise_seen & ~(wr_slow & wb_req.dat[3]));
      slow_cfg.fall_seen <= slow_fall | (slow_cfg.fall_seen & ~(wr_slow & wb_req.dat[4]));
    end
  end

  // ==========================================================
  // Result formatting and product
  function automatic logic [RES_W-1:0] fmt(input logic [RAW_W-1:0] raw, input logic signed_mode);
    if (signed_mode) begin
      return raw[RAW_W-1:1];
    end else if (raw[RAW_W-1]) begin
      return '0;
    end
    return raw[RES_W-1:0];
  endfunction

  logic [RES_W-1:0] new_bus, new_sense;
  logic signed [14:0] mul_a;
  logic signed [16:0] mul_b;
  logic signed [31:0] mul_p;
  logic [PROD_W-1:0] new_power;
  logic [ACC_W-1:0] acc_add;
  logic prod_signed;

  assign new_bus = fmt(adc_res.bus_raw, ctrl_act.bus_bipolar);
  assign new_sense = fmt(adc_res.sense_raw, ctrl_act.sense_bidir);
  assign mul_a = {ctrl_act.bus_bipolar & new_bus[RES_W-1], new_bus[RES_W-1:2]};
  assign mul_b = {ctrl_act.sense_bidir & new_sense[RES_W-1], new_sense};
  assign mul_p = mul_a * mul_b;
  assign new_power = mul_p[PROD_W-1:0];
  assign prod_signed = ctrl_act.bus_bipolar | ctrl_act.sense_bidir;
  assign acc_add = {{(ACC_W-PROD_W){prod_signed & new_power[PROD_W-1]}}, new_power};

  // ==========================================================
  // Round-robin sequencer
  logic auto_sleep;
  logic [1:0] rate_eff;

  assign auto_sleep = rate_cur != RATE_1024 || ctrl_act.chan_en != ALL_CH;
  assign rate_eff = (slow_level & ~ctrl_act.alert_sel) ? RATE_8 : ctrl_act.rate;

  function automatic logic [PERIOD_W-1:0] period_of(input logic [1:0] rate);
    case (rate)
      RATE_1024: return PERIOD_W'(CYC_1024);
      RATE_256: return PERIOD_W'(CYC_256);
      RATE_64: return PERIOD_W'(CYC_64);
      default: return PERIOD_W'(CYC_8);
    endcase
  endfunction

  logic conv_done;
  assign conv_done = state == ST_CONVERT && adc_res.done;

  always_ff @(posedge clk) begin
    if (core_rst) begin
      state <= ST_IDLE;
      ch <= 2'h0;
      rate_cur <= RATE_1024;
      period_cnt <= '0;
      warm_cnt <= '0;
      adc_start <= 1'b0;
      adc_chan <= 2'h0;
    end else begin
      adc_start <= 1'b0;
      if (period_cnt != '0) begin
        period_cnt <= period_cnt - 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (ctrl_act.mode == MODE_CONT && period_cnt == '0 && !idle_apply) begin
            // Slow pin sets the rate only here, so a running cycle finishes first
            rate_cur <= rate_eff;
            period_cnt <= period_of(rate_eff);
            ch <= 2'h0;
            state <= ST_START;
          end else if (ctrl_act.mode == MODE_SINGLE && slow_rise) begin
            warm_cnt <= '0;
            state <= ST_WARMUP;
          end
        end
        ST_WARMUP: begin
          warm_cnt <= warm_cnt + 1'b1;
          if (warm_cnt == PERIOD_W'(CYC_WARMUP - 1)) begin
            ch <= 2'h0;
            state <= ST_START;
          end
        end
        ST_START: begin
          if (ctrl_act.chan_en[ch]) begin
            adc_start <= 1'b1;
            adc_chan <= ch;
            state <= ST_CONVERT;
          end else if (ch == 2'h3) begin
            state <= ST_IDLE;
          end else begin
            ch <= ch + 1'b1;
          end
        end
        ST_CONVERT: begin
          if (adc_res.done) begin
            if (ch == 2'h3) begin
              state <= ST_IDLE;
            end else begin
              ch <= ch + 1'b1;
              state <= ST_START;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Sleep only between cycles or by commanded mode; stored data is untouched
  always_ff @(posedge clk) begin
    if (core_rst) begin
      analog_sleep <= 1'b0;
    end else begin
      analog_sleep <= state == ST_IDLE && (ctrl_act.mode != MODE_CONT || auto_sleep);
    end
  end

  // ==========================================================
  // Live results, accumulators and snapshots
  always_ff @(posedge clk) begin
    if (core_rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        live_bus[i] <= '0;
        live_sense[i] <= '0;
        live_power[i] <= '0;
        acc[i] <= '0;
        rd_bus[i] <= '0;
        rd_sense[i] <= '0;
        rd_power[i] <= '0;
        rd_acc[i] <= '0;
      end
      acc_count <= '0;
      rd_count <= '0;
    end else begin
      if (conv_done) begin
        live_bus[ch] <= new_bus;
        live_sense[ch] <= new_sense;
        live_power[ch] <= new_power;
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (snap_go && snap_clear) begin
          acc[i] <= '0;
        end else if (conv_done && ch == 2'(i)) begin
          acc[i] <= acc[i] + acc_add;
        end
        if (snap_go) begin
          rd_bus[i] <= live_bus[i];
          rd_sense[i] <= live_sense[i];
          rd_power[i] <= live_power[i];
          rd_acc[i] <= acc[i];
        end
      end
      if (snap_go && snap_clear) begin
        acc_count <= '0;
      end else if (conv_done && ch == 2'h3) begin
        acc_count <= acc_count + 1'b1;
      end
      if (snap_go) begin
        rd_count <= acc_count;
      end
    end
  end

  // ==========================================================
  // Pin and status outputs
  always_ff @(posedge clk) begin
    if (core_rst) begin
      first_alert_output <= 1'b0;
      first_alert_oe <= 1'b0;
      smbus_timeout_en <= 1'b0;
      powered_down <= 1'b1;
    end else begin
      // Open-drain: drives low only while the pin is an alert and asserted
      first_alert_output <= 1'b0;
      first_alert_oe <= ctrl_act.alert_sel & ctrl_act.alert_level;
      smbus_timeout_en <= ctrl_act.smbus_to_en;
      powered_down <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  a_sleep_cause: assert property (@(posedge clk) disable iff (core_rst)
    analog_sleep |-> $past(state) == ST_IDLE && ($past(ctrl_act.mode) != MODE_CONT || $past(auto_sleep)))
    else $error("sleep without cause");
  a_pd_no_ack: assert property (@(posedge clk) disable iff (rst)
    !pd_level |=> !wb_ack)
    else $error("bus answered in power-down");
  a_pd_defaults: assert property (@(posedge clk) disable iff (rst)
    !pd_level ##1 pd_level |-> ctrl_act == CTRL_RESET && ctrl_pend == CTRL_RESET && rd_count == '0)
    else $error("state kept across power-down");
  a_por_set: assert property (@(posedge clk)
    $fell(core_rst) |-> por_flag)
    else $error("power-on flag not set");
  a_alert_rate: assert property (@(posedge clk) disable iff (core_rst)
    (state == ST_IDLE && ctrl_act.mode == MODE_CONT && period_cnt == '0 && !idle_apply
     && ctrl_act.alert_sel) |=> rate_cur == $past(ctrl_act.rate))
    else $error("alert pin still set the rate");
  a_rate_forced: assert property (@(posedge clk) disable iff (core_rst)
    (state == ST_IDLE && ctrl_act.mode == MODE_CONT && period_cnt == '0 && !idle_apply
     && slow_level && !ctrl_act.alert_sel) |=> rate_cur == RATE_8 && state == ST_START)
    else $error("slow pin did not force 8 SPS");
  a_limited_keep: assert property (@(posedge clk) disable iff (core_rst)
    (pin_snap && !wr_cmd && !apply_pending) |=> ctrl_act == $past(ctrl_act) && !apply_pending)
    else $error("pin snapshot applied control");
  a_snap_latch: assert property (@(posedge clk) disable iff (core_rst)
    snap_go |=> rd_bus[0] == $past(live_bus[0]) && rd_count == $past(acc_count))
    else $error("snapshot did not latch");
  a_clear_snap: assert property (@(posedge clk) disable iff (core_rst)
    (snap_go && snap_clear) |=> acc_count == '0 && acc[3] == '0)
    else $error("clearing snapshot kept accumulators");
  a_warmup_hold: assert property (@(posedge clk) disable iff (core_rst)
    (state == ST_WARMUP && warm_cnt != PERIOD_W'(CYC_WARMUP - 1)) |=> state == ST_WARMUP && !adc_start)
    else $error("single-shot started early");
  a_sleep_mode_idle: assert property (@(posedge clk) disable iff (core_rst)
    (state == ST_IDLE && ctrl_act.mode == MODE_SLEEP) |=> state == ST_IDLE)
    else $error("sampling started in sleep");
endmodule
`default_nettype wire

// ---- rtl/pmsc_pkg.sv ----
// Package for the power monitor state control block: register map, field
// layouts, reset values, modes and timing constants.
// Assumes a single 250 MHz core clock and a 32-bit classic Wishbone host.
package pmsc_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_RATE_1024_NS = 976_562;
  localparam int T_RATE_256_NS = 3_906_250;
  localparam int T_RATE_64_NS = 15_625_000;
  localparam int T_RATE_8_NS = 125_000_000;
  localparam int T_WARMUP_NS = 1_000_000;
  localparam int PERIOD_W = 26;

  // ==========================================================
  // Widths
  localparam int NUM_CH = 4;
  localparam int RAW_W = 17;
  localparam int RES_W = 16;
  localparam int PROD_W = 30;
  localparam int ACC_W = 56;
  localparam int CNT_W = 32;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_SLOW = 8'h0c;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_RES_BASE = 8'h40;
  localparam logic [7:0] ADDR_RES_END = 8'hbf;
  localparam logic [2:0] RES_BUS = 3'h0;
  localparam logic [2:0] RES_SENSE = 3'h1;
  localparam logic [2:0] RES_POWER = 3'h2;
  localparam logic [2:0] RES_ACC_LO = 3'h3;
  localparam logic [2:0] RES_ACC_HI = 3'h4;

  // Command and status bit positions
  localparam int CMD_SNAP_CLR_BIT = 0;
  localparam int CMD_SNAP_KEEP_BIT = 1;
  localparam int STAT_POR_BIT = 0;
  localparam int STAT_SLEEP_BIT = 1;
  localparam int STAT_SLOW_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;

  // ==========================================================
  // Codes
  localparam logic [1:0] RATE_1024 = 2'h0;
  localparam logic [1:0] RATE_256 = 2'h1;
  localparam logic [1:0] RATE_64 = 2'h2;
  localparam logic [1:0] RATE_8 = 2'h3;
  localparam logic [1:0] MODE_CONT = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [3:0] ALL_CH = 4'hf;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [18:0] rsvd;
    logic alert_level;
    logic smbus_to_en;
    logic sense_bidir;
    logic bus_bipolar;
    logic [3:0] chan_en;
    logic alert_sel;
    logic [1:0] mode;
    logic [1:0] rate;
  } pmsc_ctrl_t;

  typedef struct packed {
    logic [25:0] rsvd;
    logic level;
    logic fall_seen;
    logic rise_seen;
    logic fall_dis;
    logic rise_dis;
    logic keep_acc;
  } pmsc_slow_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pmsc_wb_req_t;

  typedef struct packed {
    logic done;
    logic [RAW_W-1:0] bus_raw;
    logic [RAW_W-1:0] sense_raw;
  } pmsc_adc_res_t;

  localparam pmsc_ctrl_t CTRL_RESET = '{rsvd: 19'h0, alert_level: 1'b0, smbus_to_en: 1'b0,
    sense_bidir: 1'b0, bus_bipolar: 1'b0, chan_en: 4'hf, alert_sel: 1'b0, mode: 2'h0, rate: 2'h0};
  localparam pmsc_slow_t SLOW_RESET = '0;

endpackage

// ---- rtl/pmsc_sync.sv ----
// Two flip-flop synchroniser for one pin level.
// Assumes the input is asynchronous to clk; only the second stage is read.
`timescale 1ns/1ns
`default_nettype none
module pmsc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level
  input wire logic pin,
  output logic level
);
  logic stage1;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= RESET_VAL;
      level <= RESET_VAL;
    end else begin
      stage1 <= pin;
      level <= stage1;
    end
  end
endmodule
`default_nettype wire

// ---- dv/pmsc_adc_model.sv ----
// Converter model on the far side of the sequencer.
// Assumes one start pulse per conversion on the block's clock.
`timescale 1ns/1ns
`default_nettype none
module pmsc_adc_model (
  // Clock
  input wire logic clk,
  // Converter
  input wire logic adc_start,
  input wire logic [1:0] adc_chan,
  output var pmsc_pkg::pmsc_adc_res_t adc_res
);
  import pmsc_pkg::*;
  logic [3:0] cnt;
  logic [1:0] ch;
  initial begin
    cnt = 4'h0;
    ch = 2'h0;
    adc_res = '0;
  end
  // ==========================================
  // Answer six cycles after start; raw data toggles outside done
  always @(posedge clk) begin
    if (adc_start) begin
      cnt <= 4'h6;
      ch <= adc_chan;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
    adc_res.done <= (cnt == 4'h1);
    adc_res.bus_raw <= (cnt == 4'h1) ? {15'h048c, ch} : ~adc_res.bus_raw;
    adc_res.sense_raw <= (cnt == 4'h1) ? 17'h00100 : ~adc_res.sense_raw;
  end
endmodule
`default_nettype wire

// ---- dv/tb_power_monitor_state_control.sv ----
// Self-checking bench for the state control block.
// Assumes a converter model and a classic Wishbone master task.
`timescale 1ns/1ns
`default_nettype none
module tb_power_monitor_state_control;
  import pmsc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic power_down_pin = 1'b1;
  logic slow_pin_in = 1'b0;
  pmsc_wb_req_t wb_req = '0;
  pmsc_adc_res_t adc_res;
  logic wb_ack, first_alert_output, first_alert_oe, adc_start, analog_sleep, smbus_timeout_en, powered_down;
  logic [31:0] wb_dat_o;
  logic [1:0] adc_chan;
  int err_count = 0;
  int samples_checked = 0;
  pmsc_top #(.CYC_1024(40), .CYC_256(80), .CYC_64(160), .CYC_8(320), .CYC_WARMUP(20)) dut (
    .clk(clk), .rst(rst), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o),
    .power_down_pin(power_down_pin), .slow_pin_in(slow_pin_in), .first_alert_output(first_alert_output),
    .first_alert_oe(first_alert_oe), .adc_start(adc_start), .adc_chan(adc_chan), .adc_res(adc_res),
    .analog_sleep(analog_sleep), .smbus_timeout_en(smbus_timeout_en), .powered_down(powered_down));
  pmsc_adc_model adc (.clk(clk), .adc_start(adc_start), .adc_chan(adc_chan), .adc_res(adc_res));
  initial begin
    forever #2 clk = ~clk;
  end
  // ==========================================
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      err_count++;
    end
  endtask
  // Request held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_req <= '0;
    @(posedge clk);
    if (n >= 50) begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  // Bounded wait for a level on sleep (0) or timeout enable (1)
  task automatic wait_hi(input int s, input logic v);
    int n;
    n = 0;
    while (((s == 0) ? analog_sleep : smbus_timeout_en) !== v && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk(n < 2000, 1);
    if (n >= 2000) wrap_up();
  endtask
  task automatic wait_done(input int k);
    int n;
    n = 0;
    while (k > 0 && n < 20000) begin
      @(posedge clk);
      n++;
      if (adc_res.done) k--;
    end
    chk(n < 20000, 1);
    if (n >= 20000) wrap_up();
  endtask
  // ==========================================
  task automatic t_reset();
    rdm(ADDR_STATUS, 32'h1, 32'h1);
    wr(ADDR_STATUS, 32'h1);
    rdm(ADDR_STATUS, 32'h1, 32'h0);
    rdm(ADDR_CTRL, 32'hffffffff, 32'h1e0);
    rdm(8'hfc, 32'hffffffff, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_snap();
    wait_done(5);
    wr(ADDR_CMD, 32'h1);
    rdm(8'h40, 32'hffff, 32'h1230);
    rdm(8'h44, 32'hffff, 32'h0100);
    rdm(8'h48, 32'h3fffffff, 32'h48c00);
    rdm(8'h60, 32'hffff, 32'h1231);
    wr(ADDR_CTRL, 32'h7e0);
    wr(ADDR_CMD, 32'h1);
    wait_done(9);
    wr(ADDR_CMD, 32'h2);
    rdm(8'h40, 32'hffff, 32'h0918);
    rdm(8'h44, 32'hffff, 32'h0080);
    rdm(8'h48, 32'h3fffffff, 32'h12300);
    $display("test snapshot done");
  endtask
  task automatic t_sleep();
    int starts;
    starts = 0;
    wr(ADDR_CTRL, 32'h1e8);
    wr(ADDR_CMD, 32'h1);
    wait_hi(0, 1'b1);
    slow_pin_in <= 1'b1;
    repeat (400) begin
      @(posedge clk);
      starts += adc_start;
    end
    chk(starts, 0);
    rdm(ADDR_SLOW, 32'h28, 32'h28);
    rdm(ADDR_STATUS, 32'h6, 32'h6);
    wr(ADDR_CTRL, 32'h9e0);
    wr(ADDR_CMD, 32'h2);
    wait_hi(1, 1'b1);
    // Pin high forces 8 SPS, so the idle gap turns into sleep
    wait_hi(0, 1'b1);
    wr(ADDR_CTRL, 32'h19f0);
    wr(ADDR_CMD, 32'h2);
    repeat (10) @(posedge clk);
    chk(first_alert_oe, 1);
    chk(first_alert_output, 0);
    wait_hi(0, 1'b0);
    $display("test sleep done");
  endtask
  task automatic t_single();
    int n;
    n = 0;
    wr(ADDR_CTRL, 32'h1e4);
    wr(ADDR_CMD, 32'h2);
    slow_pin_in <= 1'b0;
    repeat (100) @(posedge clk);
    slow_pin_in <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (adc_start !== 1'b1 && n < 100);
    chk(n >= 20 && n < 40, 1);
    if (n >= 100) wrap_up();
    $display("test single-shot done");
  endtask
  task automatic t_pd();
    power_down_pin <= 1'b0;
    repeat (5) @(posedge clk);
    chk(powered_down, 1);
    power_down_pin <= 1'b1;
    repeat (5) @(posedge clk);
    chk(smbus_timeout_en, 0);
    rdm(ADDR_STATUS, 32'h1, 32'h1);
    rdm(ADDR_CTRL, 32'hffffffff, 32'h1e0);
    rdm(ADDR_SLOW, 32'h18, 32'h0);
    // No snapshot is sent after the release, well inside the settle time
    $display("test power-down done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_snap();
    t_sleep();
    t_single();
    t_pd();
    wrap_up();
  end
endmodule
`default_nettype wire
